// [src/rmp_defs.svh]
// Timing counts, field positions and buffer defaults for the RMII port
`ifndef RMP_DEFS_SVH
`define RMP_DEFS_SVH

// ----------------------------------------------------------------------
// Clocks and bit time
// ----------------------------------------------------------------------
`define RMP_CLK_PERIOD_PS 10000
`define RMP_REF_PERIOD_NS 20
`define RMP_BIT_TIME_PS 10000
`define RMP_REF_CYC (`RMP_REF_PERIOD_NS * 1000 / `RMP_CLK_PERIOD_PS)
`define RMP_SLOW_HOLD 10

// ----------------------------------------------------------------------
// Latencies in tenths of a bit time
// ----------------------------------------------------------------------
`define RMP_TX_LAT_BITS_X10 110
`define RMP_CRS_ON_TX_BITS_X10 185
`define RMP_CRS_ON_FX_BITS_X10 90
`define RMP_CRS_OFF_TX_BITS_X10 270
`define RMP_CRS_OFF_FX_BITS_X10 170
`define RMP_RX_LAT_TX_BITS_X10 380
`define RMP_RX_LAT_FX_BITS_X10 270

// Tenths of a bit time to clock cycles, rounded up
`define RMP_CYC_UP(t) ((((t) * `RMP_BIT_TIME_PS) / 10 + `RMP_CLK_PERIOD_PS - 1) / `RMP_CLK_PERIOD_PS)

// Register stages between a pin and the delay line taps
`define RMP_TX_PIPE_CYC 3
`define RMP_RX_PIPE_CYC 2
`define RMP_TX_SR_LEN `RMP_CYC_UP(`RMP_TX_LAT_BITS_X10)
`define RMP_RX_SR_LEN `RMP_CYC_UP(`RMP_RX_LAT_TX_BITS_X10)

// ----------------------------------------------------------------------
// Receive slot fields
// ----------------------------------------------------------------------
`define RMP_SLOT_SOS 5
`define RMP_SLOT_EOS 4
`define RMP_SLOT_STB 3
`define RMP_SLOT_ERR 2
`define RMP_SLOT_DHI 1
`define RMP_SLOT_DLO 0

// ----------------------------------------------------------------------
// Elasticity buffer
// ----------------------------------------------------------------------
`define RMP_EB_SEL_DEFAULT 2'h1
`define RMP_EB_DEPTH_DEFAULT 16

`endif

// [src/rmp_pkg.sv]
// Types shared by the RMII port modules
`include "rmp_defs.svh"

package rmp_pkg;

  typedef enum logic [2:0] {
    RMP_RX_IDLE    = 3'b001,
    RMP_RX_CARRIER = 3'b010,
    RMP_RX_DRAIN   = 3'b100
  } rmp_rx_state_e;

  typedef logic [5:0] rmp_slot_t;

  typedef struct packed {
    logic                                 ref_q;
    logic [3:0]                           div;
    logic                                 phase;
    logic [1:0]                           txd_cap;
    logic                                 tx_en_cap;
    logic [`RMP_TX_SR_LEN-1:0][1:0]       tx_sr;
    logic                                 line_tx_en;
    logic                                 line_tx_bit;
    rmp_slot_t [`RMP_RX_SR_LEN-1:0]       rx_sr;
    rmp_rx_state_e                        state;
    logic                                 started;
    logic                                 nib;
    logic                                 ovf;
    logic                                 crs_dv;
    logic                                 rx_dv;
    logic [1:0]                           rxd;
    logic                                 rx_er;
  } rmp_core_s;

endpackage

// [src/rmp_elastic_buf.sv]
// Receive elasticity buffer between line strobes and reference edges
`timescale 1ns/1ps
`include "rmp_defs.svh"

module rmp_elastic_buf #(
  parameter int DEPTH = `RMP_EB_DEPTH_DEFAULT,
  parameter int W     = 3,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          wr_valid,
  output logic               wr_ready,
  input  wire logic [W-1:0]  wr_data,
  output logic               rd_valid,
  input  wire logic          rd_ready,
  output logic [W-1:0]       rd_data,
  output logic [AW:0]        fill
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } rmp_eb_s;

  rmp_eb_s r;
  rmp_eb_s n;

  logic do_wr;
  logic do_rd;

  // ----------------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------------
  assign wr_ready = (r.cnt != (AW+1)'(DEPTH));
  assign rd_valid = (r.cnt != '0);
  assign rd_data  = r.mem[r.rp];
  assign fill     = r.cnt;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    n     = r;
    do_wr = wr_valid & wr_ready;
    do_rd = rd_ready & rd_valid;
    if (do_wr) begin
      n.mem[r.wp] = wr_data;
      n.wp        = (r.wp == AW'(DEPTH - 1)) ? '0 : AW'(r.wp + 1'b1);
    end
    if (do_rd) begin
      n.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : AW'(r.rp + 1'b1);
    end
    // Every written dibit is read exactly once RULE_14
    case ({do_wr, do_rd})
      2'b10:   n.cnt = (AW+1)'(r.cnt + 1'b1);
      2'b01:   n.cnt = (AW+1)'(r.cnt - 1'b1);
      default: n.cnt = r.cnt;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

endmodule

// [src/rmp_rmii_port.sv]
// RMII side of one 10/100 PHY port: transmit capture, receive delivery
//
// What this block does
// RULE_01: One 50 MHz reference clock serves both directions
// RULE_02: Transmit dibit and enable captured on reference rise
// RULE_03: Transmit line output about 11 bits later
// RULE_04: Receive outputs launched on reference rising edge
// RULE_05: Carrier on 18.5 bits TX, 9 FX
// RULE_06: Carrier off 27 bits TX, 17 FX
// RULE_07: Receive data 38 bits TX, 27 FX
// RULE_08: Elasticity buffer setting defaults to 01
// RULE_09: Carrier/data-valid asserts without waiting for reference; stays low if carrier starts on the reference rise that ends a drain
// RULE_10: Carrier/data-valid toggles while buffered data drains
// RULE_11: Extra synchronous receive-valid marks valid dibits
// RULE_12: One bit time is 10 ns
// RULE_13: Dibit per cycle; held ten cycles at 10M
// RULE_14: Buffer never drops or repeats dibits; a strobe into a full buffer is lost and later dibits get rx_er
`timescale 1ns/1ps
`include "rmp_defs.svh"

module rmp_rmii_port #(
  parameter logic [1:0] EB_SEL   = `RMP_EB_SEL_DEFAULT,
  parameter int         EB_DEPTH = `RMP_EB_DEPTH_DEFAULT
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       reference_clock_input,
  input  wire logic       speed_10,
  input  wire logic       fx_mode,
  input  wire logic [1:0] rmii_txd,
  input  wire logic       rmii_tx_en,
  output logic [1:0]      rmii_rxd,
  output logic            rmii_crs_dv,
  output logic            rmii_rx_dv,
  output logic            rmii_rx_er,
  output logic            line_tx_en,
  output logic            line_tx_bit,
  input  wire logic       line_rx_stb,
  input  wire logic [1:0] line_rx_dibit,
  input  wire logic       line_rx_err,
  input  wire logic       line_rx_sos,
  input  wire logic       line_rx_eos
);

  // ----------------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------------
  localparam int EB_AW = $clog2(EB_DEPTH);
  localparam logic [EB_AW:0] EB_START = (EB_AW+1)'(EB_SEL);
  localparam int REF_CYC  = `RMP_REF_CYC;
  localparam int TX_TAP   = `RMP_TX_SR_LEN - `RMP_TX_PIPE_CYC;
  localparam int ON_TX    = `RMP_CYC_UP(`RMP_CRS_ON_TX_BITS_X10);
  localparam int ON_FX    = `RMP_CYC_UP(`RMP_CRS_ON_FX_BITS_X10);
  localparam int OFF_TX   = `RMP_CYC_UP(`RMP_CRS_OFF_TX_BITS_X10);
  localparam int OFF_FX   = `RMP_CYC_UP(`RMP_CRS_OFF_FX_BITS_X10);
  localparam int LAT_TX   = `RMP_CYC_UP(`RMP_RX_LAT_TX_BITS_X10);
  localparam int LAT_FX   = `RMP_CYC_UP(`RMP_RX_LAT_FX_BITS_X10);
  localparam logic [3:0] DIV_LAST = 4'(`RMP_SLOW_HOLD - 1);
  localparam logic [3:0] DIV_HALF = 4'(`RMP_SLOW_HOLD / 2);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Delay line index for a latency in cycles, chosen by media mode
  function automatic int rx_tap(input logic fx, input int tx_cyc, input int fx_cyc);
    int cyc;
    cyc = fx ? fx_cyc : tx_cyc;
    rx_tap = cyc - `RMP_RX_PIPE_CYC;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  rmp_pkg::rmp_core_s r;
  rmp_pkg::rmp_core_s n;

  logic               ref_rise;
  logic               slot_ok;
  logic               tx_bit_sel;
  rmp_pkg::rmp_slot_t slot_in;
  rmp_pkg::rmp_slot_t on_slot;
  rmp_pkg::rmp_slot_t off_slot;
  rmp_pkg::rmp_slot_t dat_slot;
  logic               on_ev;
  logic               off_ev;
  logic               eb_wr_ready;
  logic               eb_rd_valid;
  logic               eb_rd_ready;
  logic [2:0]         eb_rd_data;
  logic [EB_AW:0]     eb_fill;

  // ----------------------------------------------------------------------
  // Reference edge and 10 Mb/s slot
  // ----------------------------------------------------------------------
  assign ref_rise = reference_clock_input & ~r.ref_q;
  assign slot_ok  = ~speed_10 | (r.div == 4'h0);

  // ----------------------------------------------------------------------
  // Receive delay line taps
  // ----------------------------------------------------------------------
  assign slot_in  = {line_rx_sos, line_rx_eos, line_rx_stb, line_rx_err, line_rx_dibit};
  assign on_slot  = r.rx_sr[rx_tap(fx_mode, ON_TX, ON_FX)];
  assign off_slot = r.rx_sr[rx_tap(fx_mode, OFF_TX, OFF_FX)];
  assign dat_slot = r.rx_sr[rx_tap(fx_mode, LAT_TX, LAT_FX)];
  assign on_ev    = on_slot[`RMP_SLOT_SOS];
  assign off_ev   = off_slot[`RMP_SLOT_EOS];

  // ----------------------------------------------------------------------
  // Elasticity buffer read gate
  // ----------------------------------------------------------------------
  // Reads start once the fill passes the depth setting RULE_08
  assign eb_rd_ready = ref_rise & slot_ok & (r.started | (eb_fill > EB_START));

  rmp_elastic_buf #(
    .DEPTH (EB_DEPTH),
    .W     (3)
  ) u_eb (
    .clk      (clk),
    .rst      (rst),
    .wr_valid (dat_slot[`RMP_SLOT_STB]),
    .wr_ready (eb_wr_ready),
    .wr_data  (dat_slot[`RMP_SLOT_ERR:`RMP_SLOT_DLO]),
    .rd_valid (eb_rd_valid),
    .rd_ready (eb_rd_ready),
    .rd_data  (eb_rd_data),
    .fill     (eb_fill)
  );

  // ----------------------------------------------------------------------
  // Transmit bit select
  // ----------------------------------------------------------------------
  // At 10 Mb/s each bit of the held dibit lasts half the slot
  always_comb begin
    if (speed_10) begin
      tx_bit_sel = (r.div == 4'h0) | (r.div > DIV_HALF); // RULE_13
    end else begin
      tx_bit_sel = r.phase;
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    n       = r;
    n.ref_q = reference_clock_input;

    // Reference phase and slow slot divider
    if (ref_rise) begin // RULE_01
      n.phase = 1'b0;
      n.div   = (r.div == DIV_LAST) ? 4'h0 : 4'(r.div + 4'h1);
    end else if (int'(r.phase) < REF_CYC - 1) begin
      n.phase = 1'b1;
    end

    // Transmit capture on the reference rising edge
    if (ref_rise & slot_ok) begin
      n.txd_cap   = rmii_txd;   // RULE_02
      n.tx_en_cap = rmii_tx_en; // RULE_02
    end

    // Transmit line delay
    n.tx_sr       = {r.tx_sr[`RMP_TX_SR_LEN-2:0], {r.tx_en_cap, r.txd_cap[tx_bit_sel]}};
    n.line_tx_en  = r.tx_sr[TX_TAP][1]; // RULE_03
    n.line_tx_bit = r.tx_sr[TX_TAP][0]; // RULE_03

    // Receive line delay, one stage per bit time
    n.rx_sr = {r.rx_sr[`RMP_RX_SR_LEN-2:0], slot_in}; // RULE_12

    // Overflow makes the frame errored instead of silently losing data
    if (dat_slot[`RMP_SLOT_STB] & ~eb_wr_ready) begin
      n.ovf = 1'b1;
    end

    // Carrier tracking
    case (r.state)
      rmp_pkg::RMP_RX_IDLE: begin
        if (on_ev) begin
          n.state  = rmp_pkg::RMP_RX_CARRIER;
          n.crs_dv = 1'b1; // RULE_05 RULE_09
        end
      end
      rmp_pkg::RMP_RX_CARRIER: begin
        if (off_ev) begin
          n.state = rmp_pkg::RMP_RX_DRAIN; // RULE_06
        end
      end
      rmp_pkg::RMP_RX_DRAIN: begin
        if (on_ev) begin
          n.state  = rmp_pkg::RMP_RX_CARRIER;
          n.crs_dv = 1'b1; // RULE_09
        end
      end
      default: begin
        n.state = rmp_pkg::RMP_RX_IDLE;
      end
    endcase

    // Receive delivery on the reference rising edge
    if (ref_rise & slot_ok) begin
      if (eb_rd_ready & eb_rd_valid) begin
        n.rxd     = eb_rd_data[1:0];              // RULE_04 RULE_07
        n.rx_er   = eb_rd_data[2] | r.ovf;        // RULE_04 RULE_07
        n.rx_dv   = 1'b1;                         // RULE_11
        n.started = 1'b1;
        n.nib     = ~r.nib;
        if (r.state == rmp_pkg::RMP_RX_DRAIN) begin
          n.crs_dv = r.nib; // RULE_10
        end
      end else if (r.started) begin
        n.rx_dv = 1'b0; // RULE_11 RULE_14
        n.rx_er = 1'b0;
        n.rxd   = 2'h0;
        if (r.state != rmp_pkg::RMP_RX_CARRIER) begin
          n.crs_dv  = 1'b0; // RULE_10
          n.started = 1'b0;
          n.nib     = 1'b0;
          n.ovf     = dat_slot[`RMP_SLOT_STB] & ~eb_wr_ready;
          if (!on_ev) begin
            n.state = rmp_pkg::RMP_RX_IDLE;
          end
        end
      end else if (r.state == rmp_pkg::RMP_RX_DRAIN) begin
        n.crs_dv = 1'b0; // RULE_06
        n.state  = on_ev ? rmp_pkg::RMP_RX_CARRIER : rmp_pkg::RMP_RX_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      r       <= '0;
      r.state <= rmp_pkg::RMP_RX_IDLE;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign rmii_rxd    = r.rxd;
  assign rmii_crs_dv = r.crs_dv;
  assign rmii_rx_dv  = r.rx_dv;
  assign rmii_rx_er  = r.rx_er;
  assign line_tx_en  = r.line_tx_en;
  assign line_tx_bit = r.line_tx_bit;

endmodule

// [testbench/rmp_mac_model.sv]
// Behavioural MAC facing the RMII pins
`timescale 1ns/1ps
module rmp_mac_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ref_clk,
  input  wire logic       speed_10,
  input  wire logic [1:0] rxd,
  input  wire logic       rx_dv,
  input  wire logic       rx_er,
  output logic [1:0]      txd,
  output logic            tx_en
);
  logic [1:0] tx_q [$];
  logic [2:0] rx_q [$];
  int         hold;
  initial begin
    txd = 2'h0;
    tx_en = 1'b0;
    hold = 0;
  end
  // ----
  // Launch after a reference rise, hold one period or ten
  // ----
  always @(negedge clk) begin
    if (rst) begin
      tx_en <= 1'b0;
      hold <= 0;
    end else if (ref_clk) begin
      if (hold > 0) begin
        hold <= hold - 1;
      end else if (tx_q.size() > 0) begin
        txd <= tx_q.pop_front();
        tx_en <= 1'b1;
        hold <= speed_10 ? 9 : 0;
      end else begin
        tx_en <= 1'b0;
        txd <= ~txd;
      end
    end
  end
  // ----
  // Take one dibit per reference rise while valid, at 100 Mb/s only
  // ----
  always @(posedge clk) begin
    if (!rst && ref_clk && rx_dv && !speed_10) begin
      rx_q.push_back({rx_er, rxd});
    end
  end
endmodule

// [testbench/rmp_rmii_port_monitor.sv]
// Pin-level assertions for the RMII port
`timescale 1ns/1ps
module rmp_rmii_port_monitor #(
  parameter logic [1:0] EB_SEL   = 2'h1,
  parameter int         EB_DEPTH = 16
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       reference_clock_input,
  input wire logic       speed_10,
  input wire logic       fx_mode,
  input wire logic [1:0] rmii_txd,
  input wire logic       rmii_tx_en,
  input wire logic [1:0] rmii_rxd,
  input wire logic       rmii_crs_dv,
  input wire logic       rmii_rx_dv,
  input wire logic       rmii_rx_er,
  input wire logic       line_tx_en,
  input wire logic       line_tx_bit,
  input wire logic       line_rx_stb,
  input wire logic [1:0] line_rx_dibit,
  input wire logic       line_rx_err,
  input wire logic       line_rx_sos,
  input wire logic       line_rx_eos
);
  logic ref_q;
  logic ref_rise;
  always_ff @(posedge clk) begin
    ref_q <= reference_clock_input;
  end
  assign ref_rise = reference_clock_input & ~ref_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // Assertions
  // ----
  tx_bit0_a: assert property (
    ref_rise && rmii_tx_en && !speed_10 |->
    ##11 line_tx_en && line_tx_bit == $past(rmii_txd[0], 11)) else $error("line bit0 wrong");
  tx_bit1_a: assert property (
    ref_rise && rmii_tx_en && !speed_10 |->
    ##12 line_tx_bit == $past(rmii_txd[1], 12)) else $error("line bit1 wrong");
  tx_slow_a: assert property (
    speed_10 && $past(speed_10, 12) && $changed(line_tx_bit) |=>
    $stable(line_tx_bit)[*8] ##1 $stable(line_tx_bit))
    else $error("slow line bit too short");
  crs_on_tx_a: assert property (
    line_rx_sos && !fx_mode && !rmii_crs_dv |-> (!rmii_crs_dv)[*8] ##[11:13] rmii_crs_dv)
    else $error("carrier on late or early");
  crs_on_fx_a: assert property (
    line_rx_sos && fx_mode && !rmii_crs_dv |-> (!rmii_crs_dv)[*4] ##[5:7] rmii_crs_dv)
    else $error("fiber carrier on wrong");
  crs_off_tx_a: assert property (
    line_rx_eos && !fx_mode && rmii_crs_dv |-> rmii_crs_dv[*8] ##[19:26] !rmii_crs_dv)
    else $error("carrier off wrong");
  rxd_launch_a: assert property (
    $changed(rmii_rxd) |-> $past(ref_rise)) else $error("rxd off reference");
  crs_fall_a: assert property (
    $fell(rmii_crs_dv) |-> $past(ref_rise)) else $error("carrier fall off reference");
  rxdv_launch_a: assert property (
    $changed(rmii_rx_dv) |-> $past(ref_rise)) else $error("rx valid off reference");
  rxd_idle_a: assert property (
    !rmii_rx_dv |-> rmii_rxd == 2'h0) else $error("rxd not zero when invalid");
endmodule

bind rmp_rmii_port rmp_rmii_port_monitor #(.EB_SEL(EB_SEL), .EB_DEPTH(EB_DEPTH))
  rmp_rmii_port_monitor_i (
  .clk(clk), .rst(rst), .reference_clock_input(reference_clock_input),
  .speed_10(speed_10), .fx_mode(fx_mode), .rmii_txd(rmii_txd), .rmii_tx_en(rmii_tx_en),
  .rmii_rxd(rmii_rxd), .rmii_crs_dv(rmii_crs_dv), .rmii_rx_dv(rmii_rx_dv),
  .rmii_rx_er(rmii_rx_er), .line_tx_en(line_tx_en), .line_tx_bit(line_tx_bit),
  .line_rx_stb(line_rx_stb), .line_rx_dibit(line_rx_dibit), .line_rx_err(line_rx_err),
  .line_rx_sos(line_rx_sos), .line_rx_eos(line_rx_eos));

// [testbench/rmp_rmii_port_tb.sv]
// Self-checking bench for the RMII port
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("unexpected %0t got %0h want %0h", $time, (a), (e)); end end
module rmp_rmii_port_tb;
  typedef struct {logic spd; logic fx; int n; int err_at; int gap_at; int rx_lat;} rmp_row_s;
  rmp_row_s rows [4] = '{'{1'b0, 1'b0, 24, -1, -1, 38}, '{1'b0, 1'b1, 24, 5, -1, 27},
                         '{1'b0, 1'b0, 40, 7, 12, 38}, '{1'b1, 1'b0, 6, -1, -1, 0}};
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       ref_clk = 1'b0;
  logic       spd = 1'b0;
  logic       fx = 1'b0;
  logic [1:0] txd, rxd;
  logic [1:0] dib = 2'h0;
  logic       tx_en, crs, dv, er, ltx_en, ltx_bit;
  logic       stb = 1'b0, lerr = 1'b0, sos = 1'b0, eos = 1'b0;
  logic       lbits [$];
  int         failures = 0, checks = 0, cyc = 0, t_sos = 0, t_dv = -1, lcnt = 0, k;
  rmp_rmii_port rmp_rmii_port_i (
    .clk(clk), .rst(rst), .reference_clock_input(ref_clk), .speed_10(spd), .fx_mode(fx),
    .rmii_txd(txd), .rmii_tx_en(tx_en), .rmii_rxd(rxd), .rmii_crs_dv(crs), .rmii_rx_dv(dv),
    .rmii_rx_er(er), .line_tx_en(ltx_en), .line_tx_bit(ltx_bit), .line_rx_stb(stb),
    .line_rx_dibit(dib), .line_rx_err(lerr), .line_rx_sos(sos), .line_rx_eos(eos));
  rmp_mac_model rmp_mac_model_i (
    .clk(clk), .rst(rst), .ref_clk(ref_clk), .speed_10(spd), .rxd(rxd), .rx_dv(dv),
    .rx_er(er), .txd(txd), .tx_en(tx_en));
  always #5 clk = ~clk;
  always @(negedge clk) ref_clk <= rst ? 1'b0 : ~ref_clk;
  // ----
  // Line observer: one sample per line bit
  // ----
  always @(posedge clk) begin
    cyc++;
    if (sos) t_sos = cyc;
    if (dv && t_dv < 0) t_dv = cyc;
    if (ltx_en) begin
      if (lcnt == 0) lbits.push_back(ltx_bit);
      lcnt = (lcnt == (spd ? 9 : 0)) ? 0 : lcnt + 1;
    end else lcnt = 0;
  end
  task automatic rx_frame(input int n, input int err_at, input int gap_at);
    t_dv = -1;
    rmp_mac_model_i.rx_q.delete();
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      sos = (i == 0);
      stb = 1'b1;
      dib = 2'(i ^ (i >> 2));
      lerr = (i == err_at);
      @(negedge clk);
      sos = 1'b0;
      stb = 1'b0;
      lerr = 1'b0;
      if (i == gap_at) repeat (10) @(negedge clk);
    end
    @(negedge clk);
    eos = 1'b1;
    @(negedge clk);
    eos = 1'b0;
    repeat (120) @(negedge clk);
  endtask
  task automatic check_rx(input int n, input int err_at);
    `CHK(rmp_mac_model_i.rx_q.size(), n)
    for (int i = 0; i < n; i++) begin
      `CHK(rmp_mac_model_i.rx_q[i], {1'(i == err_at), 2'(i ^ (i >> 2))})
    end
  endtask
  task automatic tx_frame(input int n);
    lbits.delete();
    for (int i = 0; i < n; i++) rmp_mac_model_i.tx_q.push_back(2'(i * 3));
    k = 0;
    while (ltx_en !== 1'b1 && k < 400) begin @(negedge clk); k++; end
    k = 0;
    while (ltx_en !== 1'b0 && k < 2000) begin @(negedge clk); k++; end
    `CHK(lbits.size(), 2 * n)
    for (int i = 0; i < n; i++) begin
      `CHK({lbits[2 * i + 1], lbits[2 * i]}, 2'(i * 3))
    end
  endtask
  task automatic final_report();
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    `CHK({crs, dv, er, rxd, ltx_en}, 6'h00)
    foreach (rows[r]) begin
      spd = rows[r].spd;
      fx = rows[r].fx;
      if (!rows[r].spd) begin
        rx_frame(rows[r].n, rows[r].err_at, rows[r].gap_at);
        check_rx(rows[r].n, rows[r].err_at);
        `CHK((t_dv - t_sos) inside {[rows[r].rx_lat + 1 : rows[r].rx_lat + 7]}, 1'b1)
      end
      tx_frame(rows[r].n);
    end
    spd = 1'b0;
    fx = 1'b0;
    fork
      rx_frame(30, -1, -1);
      begin
        repeat (50) @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        `CHK({crs, dv, er, rxd, ltx_en, ltx_bit}, 7'h00)
        rst = 1'b0;
      end
    join
    rx_frame(8, 3, -1);
    check_rx(8, 3);
    tx_frame(4);
    final_report();
  end
endmodule
